// *** verilog/sbc_top.sv ***
// Synchronous burst SRAM: control capture, burst address and data pipe
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Address captured on rising clock edge
// - All synchronous inputs captured on rising edge
// - Edges ignored while clock qualify is high
// - Lane written only when select and enable low
// - Write starts only with write enable low
// - Advance high steps the burst counter
// - Advance low loads a fresh address
// - First enable, active low, joins selection
// - Selected needs second high, others low
// - Third enable high always deselects
// - Qualify high freezes state, keeps selection
// - Read data driven one clock after capture
// - Outputs off on write, wake, deselect
module sbc_top (
    // Clock and reset
    input  wire logic                      CLK,
    input  wire logic                      RST_B,
    // Address
    input  wire logic [sbc_pkg::HI_W-1:0]  ADDR_HI,
    input  wire logic                      BURST_ADDR_BIT0,
    input  wire logic                      BURST_ADDR_BIT1,
    // Byte lane write selects
    input  wire logic                      LANE0_WRITE_SEL_N,
    input  wire logic                      LANE1_WRITE_SEL_N,
    input  wire logic                      LANE2_WRITE_SEL_N,
    input  wire logic                      LANE3_WRITE_SEL_N,
    // Access control
    input  wire logic                      WRITE_EN_N,
    input  wire logic                      ADVANCE_OR_LOAD,
    input  wire logic                      CLK_QUALIFY_N,
    // Chip enables
    input  wire logic                      SELECT_LOW_FIRST_N,
    input  wire logic                      SELECT_HIGH_SECOND,
    input  wire logic                      SELECT_LOW_THIRD_N,
    // Data lanes, input side
    input  wire logic [sbc_pkg::DATA_W-1:0] DATA_I,
    input  wire logic [sbc_pkg::LANES-1:0]  PARITY_I,
    // Data lanes, output side
    output logic      [sbc_pkg::DATA_W-1:0] DATA_O,
    output logic      [sbc_pkg::LANES-1:0]  PARITY_O,
    output logic                            DATA_OE
);
    import sbc_pkg::*;

    // Edge qualification
    logic                qual;          // This edge is recognised

    // Selection decode
    logic                selected;      // All three enables agree
    logic                load;          // Fresh address this edge
    logic                advance;       // Burst step this edge

    // Capture stage: the access taken on the last qualified edge
    sbc_op_t             op_reg;        // Access kind in flight
    sbc_op_t             op_next;
    logic [HI_W-1:0]     hi_reg;        // Upper address of the burst
    logic [HI_W-1:0]     hi_next;
    logic [ADDR_W-1:0]   addr_reg;      // Word address in flight
    logic [LANES-1:0]    lane_n_reg;    // Lane selects in flight
    logic [LANES-1:0]    lane_n_in;     // Lane select pins as a bus

    // Burst index from the counter
    logic [BURST_W-1:0]  burst_start;   // Index pins as a bus
    logic [BURST_W-1:0]  burst_idx;     // Index for this edge

    // Array read path
    logic [WORD_W-1:0]   rd_word;       // Word at the captured address

    // Buffer handshakes
    logic                buf_in_valid;  // Read result offered
    logic                buf_in_ready;  // Buffer has room
    logic                buf_out_valid; // Head holds a word
    logic                buf_out_ready; // Output stage takes the head
    logic [WORD_W-1:0]   buf_out_data;  // Head word

    // Output drive
    logic                data_oe_reg;   // Drive the data lanes
    logic                data_oe_next;

    // Clock qualify is active low; a high level masks the edge
    assign qual = !CLK_QUALIFY_N;

    // Selection needs first low, second high and third low
    assign selected = !SELECT_LOW_FIRST_N
                   && SELECT_HIGH_SECOND
                   && !SELECT_LOW_THIRD_N;

    // Advance low loads; advance high steps the burst
    assign load    = !ADVANCE_OR_LOAD;
    // A step after deselect has no burst to continue
    assign advance = ADVANCE_OR_LOAD && (op_reg != SBC_DESEL);

    // Gather the split pins into buses
    assign burst_start = {BURST_ADDR_BIT1, BURST_ADDR_BIT0};
    assign lane_n_in   = {LANE3_WRITE_SEL_N, LANE2_WRITE_SEL_N,
                          LANE1_WRITE_SEL_N, LANE0_WRITE_SEL_N};

    // Burst counter; moves only on qualified, selected edges
    sbc_burst_cnt u_burst (
        .clk      (CLK),
        .rst_b    (RST_B),
        .qual     (qual && selected),
        .load     (load),
        .advance  (advance),
        .start    (burst_start),
        .idx_next (burst_idx)
    );

    // Decide the access taken on this edge
    always_comb begin
        op_next = op_reg;
        hi_next = hi_reg;
        if (!selected) begin
            // Any enable out of place deselects the device
            op_next = SBC_DESEL;
        end else if (load) begin
            // Fresh address; write enable picks the kind
            hi_next = ADDR_HI;
            op_next = WRITE_EN_N ? SBC_READ : SBC_WRITE;
        end else if (!advance) begin
            // Step after deselect: stay idle until a load
            op_next = SBC_DESEL;
        end
    end

    // Capture stage registers; frozen while the edge is masked
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            op_reg     <= SBC_DESEL;
            hi_reg     <= HI_RST;
            addr_reg   <= {HI_RST, BURST_RST};
            lane_n_reg <= LANE_RST;
        end else if (qual) begin
            op_reg     <= op_next;
            hi_reg     <= hi_next;
            addr_reg   <= {hi_next, burst_idx};
            // Lane selects are sampled with every beat
            lane_n_reg <= lane_n_in;
        end
    end

    // One array per lane; data and parity share a lane word
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LANE_MEM_W-1:0] lane_mem [0:DEPTH-1];  // Lane storage

        // Write data follows its address by one qualified edge.
        // Only a write access with this lane's select low lands.
        always_ff @(posedge CLK) begin
            if (qual && op_reg == SBC_WRITE
                && !lane_n_reg[l]) begin
                lane_mem[addr_reg] <=
                    {PARITY_I[l], DATA_I[l*LANE_W +: LANE_W]};
            end
        end

        // Read the lane at the captured address
        assign rd_word[l*LANE_W +: LANE_W] =
            lane_mem[addr_reg][LANE_W-1:0];
        assign rd_word[PAR_LSB + l] =
            lane_mem[addr_reg][LANE_W];
    end

    // Offer a read result on the edge after its address was taken.
    // A full buffer does not take the read; the word is dropped, not held back.
    assign buf_in_valid  = qual && (op_reg == SBC_READ);
    // The output stage moves on every recognised edge
    assign buf_out_ready = qual;

    // Two-entry buffer between the array and the data lanes
    sbc_fifo2 #(
        .WIDTH (WORD_W)
    ) u_buf (
        .clk       (CLK),
        .rst_b     (RST_B),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (rd_word),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    // Drive decision for the cycle after this edge.
    // Outputs drive only while a pushed read word sits at the head.
    // A write beat, a deselected beat and the beat right after
    // a wake from deselect all leave the capture stage without a
    // read, so the lanes stay off in those cycles.
    always_comb begin
        data_oe_next = data_oe_reg;
        if (qual) begin
            unique case (op_reg)
                SBC_READ: begin
                    data_oe_next = buf_in_ready;
                end
                SBC_WRITE: begin
                    data_oe_next = 1'b0;
                end
                SBC_DESEL: begin
                    data_oe_next = 1'b0;
                end
            endcase
        end
    end

    // Output enable register; held while the edge is masked
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            data_oe_reg <= 1'b0;
        end else begin
            data_oe_reg <= data_oe_next;
        end
    end

    // Data and parity come from the buffer head register
    assign DATA_O   = buf_out_data[DATA_W-1:0];
    assign PARITY_O = buf_out_data[PAR_LSB +: LANES];
    // Drive comes from its own register, never from the head flag
    assign DATA_OE  = data_oe_reg;

    // Head validity is implied by the drive register; kept
    // readable for debug probes without a second output
    logic unused_ok;
    assign unused_ok = buf_out_valid;

endmodule : sbc_top
`default_nettype wire

// *** verilog/sbc_pkg.sv ***
// Shared constants and types for the synchronous burst SRAM control front end
package sbc_pkg;

    // Array geometry: 1M words of four 9-bit lanes
    localparam int ADDR_W    = 20;        // Full word address width
    localparam int HI_W      = 18;        // Address bits above the burst index
    localparam int BURST_W   = 2;         // Burst index width
    localparam int LANES     = 4;         // Byte lanes per word
    localparam int LANE_W    = 8;         // Data bits per lane
    localparam int LANE_MEM_W = 9;        // Data plus parity per lane
    localparam int DATA_W    = 32;        // Data bits per word
    localparam int WORD_W    = 36;        // Data plus parity per word
    localparam int DEPTH     = 1048576;   // Words in the array

    // Field positions inside a buffered read word
    localparam int PAR_LSB   = 32;        // Parity bits sit above the data

    // Reset values, full fill count and burst step
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [HI_W-1:0]    HI_RST    = 18'h0;
    localparam logic [LANES-1:0]   LANE_RST  = 4'hf;
    localparam logic [1:0]         FILL_RST  = 2'h0;
    localparam logic [1:0]         FILL_FULL = 2'h2;
    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

    // Access held in the capture stage
    typedef enum logic [2:0] {
        SBC_DESEL = 3'b001,
        SBC_READ  = 3'b010,
        SBC_WRITE = 3'b100
    } sbc_op_t;

endpackage : sbc_pkg

// *** verilog/sbc_burst_cnt.sv ***
// Burst index counter: loads a start index or steps linearly
`timescale 1ns/1ps
`default_nettype none
module sbc_burst_cnt (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // Control from the capture logic
    input  wire logic                        qual,
    input  wire logic                        load,
    input  wire logic                        advance,
    input  wire logic [sbc_pkg::BURST_W-1:0] start,
    // Index for the access taken on this edge
    output logic      [sbc_pkg::BURST_W-1:0] idx_next
);
    import sbc_pkg::*;

    logic [BURST_W-1:0] idx_reg;   // Index of the last access

    // Load wins over advance; otherwise the index holds
    always_comb begin
        if (load) begin
            idx_next = start;
        end else if (advance) begin
            idx_next = idx_reg + BURST_ONE;
        end else begin
            idx_next = idx_reg;
        end
    end

    // Only a qualified edge moves the counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_reg <= BURST_RST;
        end else if (qual) begin
            idx_reg <= idx_next;
        end
    end

endmodule : sbc_burst_cnt
`default_nettype wire

// *** verilog/sbc_fifo2.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sbc_fifo2 #(
    parameter int WIDTH = 36
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import sbc_pkg::*;

    logic [WIDTH-1:0] head_reg;    // Oldest entry, drives the output
    logic [WIDTH-1:0] tail_reg;    // Second entry
    logic [1:0]       fill_reg;    // Entries held, zero to two
    logic             push;
    logic             pop;

    // Flags come straight from the fill count, so they never lie
    assign in_ready  = (fill_reg != FILL_FULL);
    assign out_valid = (fill_reg != FILL_RST);
    assign out_data  = head_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Fill count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fill_reg <= FILL_RST;
        end else if (push && !pop) begin
            fill_reg <= fill_reg + 2'h1;
        end else if (pop && !push) begin
            fill_reg <= fill_reg - 2'h1;
        end
    end

    // Storage; no reset needed on data
    always_ff @(posedge clk) begin
        if (push && pop) begin
            if (fill_reg == 2'h1) begin
                head_reg <= in_data;
            end else begin
                head_reg <= tail_reg;
                tail_reg <= in_data;
            end
        end else if (push) begin
            if (fill_reg == FILL_RST) begin
                head_reg <= in_data;
            end else begin
                tail_reg <= in_data;
            end
        end else if (pop) begin
            head_reg <= tail_reg;
        end
    end

endmodule : sbc_fifo2
`default_nettype wire

// *** dv/sbc_host_model.sv ***
// Memory controller model driving the synchronous access port
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model (
    // Clock from the bench
    input  wire logic        clk,
    // Access controls, changed 10 ns after each rising edge
    output logic      [19:0] addr,
    output logic      [3:0]  lane_n,
    output logic             wen,
    output logic             adv,
    output logic             qual_n,
    output logic      [2:0]  en,
    // Write data, one taken edge behind its address
    output logic      [31:0] din,
    output logic      [3:0]  pin
);
    logic [35:0] pend;   // Word waiting for its data edge
    logic        pend_w; // Pending access is a write

    // Idle and deselected from time zero
    initial begin
        {addr, lane_n, wen, adv, qual_n} = {20'h0, 4'hf, 3'h4};
        {en, din, pin, pend, pend_w} = {3'h4, 36'h0, 36'h0, 1'h0};
    end

    // One bus cycle; a masked cycle leaves the data phase where it is
    task automatic cyc(input logic q, input logic [2:0] e,
                       input logic a_n, input logic w_n,
                       input logic [3:0] l, input logic [19:0] a,
                       input logic [35:0] d);
        @(posedge clk);
        #10;
        if (q) begin
            // Released data lines flip to the inverse of their last value on each taken cycle
            {pin, din} = pend_w ? pend : ~{pin, din};
            pend = d;
            pend_w = !a_n && !w_n && e == 3'h2;
        end
        {en, adv, wen, lane_n, addr, qual_n} = {e, a_n, w_n, l, a, !q};
    endtask : cyc
endmodule : sbc_host_model
`default_nettype wire

// *** dv/sbc_top_assertions.sv ***
// Checker for control capture and output drive of the SRAM front end
`timescale 1ns/1ps
`default_nettype none
module sbc_top_assertions (
    // Clock, reset, address
    input wire logic CLK, RST_B, BURST_ADDR_BIT0, BURST_ADDR_BIT1,
    input wire logic [sbc_pkg::HI_W-1:0] ADDR_HI,
    // Lane selects and access control
    input wire logic LANE0_WRITE_SEL_N, LANE1_WRITE_SEL_N,
    input wire logic LANE2_WRITE_SEL_N, LANE3_WRITE_SEL_N,
    input wire logic WRITE_EN_N, ADVANCE_OR_LOAD, CLK_QUALIFY_N,
    // Chip enables
    input wire logic SELECT_LOW_FIRST_N, SELECT_HIGH_SECOND,
    input wire logic SELECT_LOW_THIRD_N,
    // Data
    input wire logic [sbc_pkg::DATA_W-1:0] DATA_I, DATA_O,
    input wire logic [sbc_pkg::LANES-1:0]  PARITY_I, PARITY_O,
    input wire logic DATA_OE
);
    import sbc_pkg::*;
    // Taken edge, selection, and the two kinds of load
    wire q = !CLK_QUALIFY_N;
    wire s = !SELECT_LOW_FIRST_N && SELECT_HIGH_SECOND && !SELECT_LOW_THIRD_N;
    wire rd = q && s && !ADVANCE_OR_LOAD && WRITE_EN_N;
    wire wr = q && s && !ADVANCE_OR_LOAD && !WRITE_EN_N;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    AST_READ_OE: assert property (rd ##1 q |=> DATA_OE)
        else $error("read word not driven");
    AST_WRITE_OFF: assert property (wr ##1 q |=> !DATA_OE)
        else $error("drive during write data");
    AST_FIRST_OFF: assert property (
        q && SELECT_LOW_FIRST_N ##1 q |=> !DATA_OE)
        else $error("first enable high still drives");
    AST_SECOND_OFF: assert property (
        q && !SELECT_HIGH_SECOND ##1 q |=> !DATA_OE)
        else $error("second enable low still drives");
    AST_THIRD_OFF: assert property (
        q && SELECT_LOW_THIRD_N ##1 q |=> !DATA_OE)
        else $error("third enable high still drives");
    AST_BURST_OE: assert property (
        rd ##1 q && s && ADVANCE_OR_LOAD ##1 q |=> DATA_OE)
        else $error("burst step not read");
    AST_WAKE_OFF: assert property (
        q && !s ##1 q && s && ADVANCE_OR_LOAD ##1 q |=> !DATA_OE)
        else $error("advance after deselect drives");
    AST_FREEZE_OE: assert property (CLK_QUALIFY_N |=> $stable(DATA_OE))
        else $error("masked edge moved drive");
    AST_FREEZE_DATA: assert property (
        CLK_QUALIFY_N && DATA_OE |=> $stable({PARITY_O, DATA_O}))
        else $error("masked edge moved data");
endmodule : sbc_top_assertions

bind sbc_top sbc_top_assertions chk_u (
    .CLK(CLK), .RST_B(RST_B), .ADDR_HI(ADDR_HI),
    .BURST_ADDR_BIT0(BURST_ADDR_BIT0), .BURST_ADDR_BIT1(BURST_ADDR_BIT1),
    .LANE0_WRITE_SEL_N(LANE0_WRITE_SEL_N),
    .LANE1_WRITE_SEL_N(LANE1_WRITE_SEL_N),
    .LANE2_WRITE_SEL_N(LANE2_WRITE_SEL_N),
    .LANE3_WRITE_SEL_N(LANE3_WRITE_SEL_N),
    .WRITE_EN_N(WRITE_EN_N), .ADVANCE_OR_LOAD(ADVANCE_OR_LOAD),
    .CLK_QUALIFY_N(CLK_QUALIFY_N), .SELECT_LOW_FIRST_N(SELECT_LOW_FIRST_N),
    .SELECT_HIGH_SECOND(SELECT_HIGH_SECOND),
    .SELECT_LOW_THIRD_N(SELECT_LOW_THIRD_N),
    .DATA_I(DATA_I), .DATA_O(DATA_O), .PARITY_I(PARITY_I),
    .PARITY_O(PARITY_O), .DATA_OE(DATA_OE)
);
`default_nettype wire

// *** dv/sbc_top_bench.sv ***
// Self-checking bench for the SRAM control front end
`timescale 1ns/1ps
`default_nettype none
module sbc_top_bench;
    import sbc_pkg::*;
    localparam logic [2:0] ON = 3'h2; // Selected enable pattern
    localparam logic [2:0] OFF = 3'h4; // Third enable high
    logic CLK, RST_B, wen, adv, qn, oe;
    logic [19:0] addr;
    logic [3:0] ln, pi, po;
    logic [2:0] en;
    logic [31:0] di, dout;
    logic [35:0] mem [int]; // Expected array contents
    int n_errors = 0;
    int num_checks = 0;

    sbc_host_model host_u (.clk(CLK), .addr(addr), .lane_n(ln), .wen(wen),
        .adv(adv), .qual_n(qn), .en(en), .din(di), .pin(pi));
    sbc_top dut_u (.CLK(CLK), .RST_B(RST_B), .ADDR_HI(addr[19:2]),
        .BURST_ADDR_BIT0(addr[0]), .BURST_ADDR_BIT1(addr[1]),
        .LANE0_WRITE_SEL_N(ln[0]), .LANE1_WRITE_SEL_N(ln[1]),
        .LANE2_WRITE_SEL_N(ln[2]), .LANE3_WRITE_SEL_N(ln[3]),
        .WRITE_EN_N(wen), .ADVANCE_OR_LOAD(adv), .CLK_QUALIFY_N(qn),
        .SELECT_LOW_FIRST_N(en[0]), .SELECT_HIGH_SECOND(en[1]),
        .SELECT_LOW_THIRD_N(en[2]), .DATA_I(di), .PARITY_I(pi),
        .DATA_O(dout), .PARITY_O(po), .DATA_OE(oe));

    // 100 ns clock
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    task automatic print_verdict();
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [36:0] seen, input logic [36:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // Lanes whose select is low take the new byte and its parity bit
    function automatic logic [35:0] merge(logic [35:0] o, n, logic [3:0] l);
        for (int i = 0; i < 4; i++) begin
            if (!l[i]) {o[32+i], o[8*i+:8]} = {n[32+i], n[8*i+:8]};
        end
        return o;
    endfunction : merge

    // Taken cycle; the expected array follows only selected loaded writes
    task automatic op(input logic [2:0] e, input logic a_n, w_n,
                      input logic [3:0] l, input logic [19:0] a,
                      input logic [35:0] d);
        host_u.cyc(1'b1, e, a_n, w_n, l, a, d);
        if (e == ON && !a_n && !w_n) mem[a] = merge(mem[a], d, l);
    endtask : op

    task automatic idle(input int n);
        repeat (n) op(OFF, 1'b0, 1'b1, 4'hf, 20'h0, 36'h0);
    endtask : idle

    task automatic word(input logic [19:0] a);
        check({oe, po, dout}, {1'b1, mem[a]});
    endtask : word

    // Back-to-back writes then reads; read keeps lane selects low
    task automatic s_rw();
        op(ON, 1'b0, 1'b0, 4'h0, 20'h12345, 36'h9a5c3f01e);
        op(ON, 1'b0, 1'b0, 4'h0, 20'habcde, 36'h6f00ff11c);
        op(ON, 1'b0, 1'b1, 4'h0, 20'h12345, 36'h0);
        check({36'h0, oe}, 37'h0);
        op(ON, 1'b0, 1'b1, 4'h0, 20'habcde, 36'h0);
        idle(1);
        word(20'h12345);
        idle(1);
        word(20'habcde);
        idle(1);
        check({36'h0, oe}, 37'h0);
    endtask : s_rw

    // Single-lane and no-lane writes over a full word
    task automatic s_lanes();
        logic [3:0] m [5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hf};
        op(ON, 1'b0, 1'b0, 4'h0, 20'h00777, 36'h0);
        foreach (m[i]) op(ON, 1'b0, 1'b0, m[i], 20'h00777, {9{4'(i + 5)}});
        op(ON, 1'b0, 1'b1, 4'h0, 20'h00777, 36'h0);
        idle(2);
        word(20'h00777);
    endtask : s_lanes

    // Linear burst from index 2 wraps to 0; address pins ignored meanwhile
    task automatic s_burst();
        for (int i = 0; i < 4; i++) begin
            op(ON, 1'b0, 1'b0, 4'h0, 20'h55550 + 20'(i),
               36'(i) * 36'h111111111);
        end
        op(ON, 1'b0, 1'b1, 4'hf, 20'h55552, 36'h0);
        for (int i = 1; i < 6; i++) begin
            if (i < 4) op(ON, 1'b1, 1'b1, 4'hf, 20'hfffff, 36'h0);
            else idle(1);
            if (i > 1) word(20'h55550 + 20'((i + 0) % 4));
        end
    endtask : s_burst

    // Each enable alone deselects: neither the write nor the read happens
    task automatic s_desel();
        logic [2:0] off [3] = '{3'h3, 3'h0, 3'h6};
        op(ON, 1'b0, 1'b0, 4'h0, 20'h0c0c0, 36'h123456789);
        foreach (off[i]) begin
            op(off[i], 1'b0, 1'b0, 4'h0, 20'h0c0c0, 36'hfedcba987);
            op(off[i], 1'b0, 1'b1, 4'h0, 20'h0c0c0, 36'h0);
            // A step right after deselect must not start an access
            op(ON, 1'b1, 1'b1, 4'h0, 20'h0c0c0, 36'h0);
            op(ON, 1'b0, 1'b1, 4'h0, 20'h0c0c0, 36'h0);
            check({36'h0, oe}, 37'h0);
            idle(1);
            check({36'h0, oe}, 37'h0);
            idle(1);
            word(20'h0c0c0);
        end
    endtask : s_desel

    // Masked edges with a selected write on the pins change nothing
    task automatic s_freeze();
        op(ON, 1'b0, 1'b0, 4'h0, 20'h0abab, 36'h3c3c3c3c3);
        op(ON, 1'b0, 1'b1, 4'h0, 20'h0abab, 36'h0);
        repeat (3) host_u.cyc(1'b0, ON, 1'b0, 1'b0, 4'h0, 20'h0abab, 36'h0);
        // The held-back read only moves on the next taken edge
        idle(1);
        check({36'h0, oe}, 37'h0);
        repeat (3) host_u.cyc(1'b0, ON, 1'b0, 1'b0, 4'h0, 20'h0abab, 36'h0);
        word(20'h0abab);
        op(ON, 1'b0, 1'b1, 4'h0, 20'h0abab, 36'h0);
        idle(2);
        word(20'h0abab);
    endtask : s_freeze

    // Reset for three cycles, then the scenarios
    initial begin
        RST_B = 1'b0;
        repeat (3) @(posedge CLK);
        #10;
        RST_B = 1'b1;
        s_rw();
        s_lanes();
        s_burst();
        s_desel();
        s_freeze();
        print_verdict();
    end

    // Watchdog well beyond the 60 or so cycles that reset and the scenarios need
    initial begin
        repeat (2000) @(posedge CLK);
        n_errors++;
        print_verdict();
    end
endmodule : sbc_top_bench
`default_nettype wire
